/* verilog/tcc_pkg.sv */
package tcc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TCC_ADDR_CAPT_LOW  = 8'h26;
  localparam logic [7:0] TCC_ADDR_CAPT_HIGH = 8'h27;
  localparam logic [7:0] TCC_ADDR_CMPB_LOW  = 8'h28;
  localparam logic [7:0] TCC_ADDR_CMPB_HIGH = 8'h29;
  localparam logic [7:0] TCC_ADDR_CMPA_LOW  = 8'h2A;
  localparam logic [7:0] TCC_ADDR_CMPA_HIGH = 8'h2B;
  localparam logic [7:0] TCC_ADDR_CNT_LOW   = 8'h2C;
  localparam logic [7:0] TCC_ADDR_CNT_HIGH  = 8'h2D;
  localparam logic [7:0] TCC_ADDR_CTRL_B    = 8'h2E;
  localparam logic [7:0] TCC_ADDR_CTRL_A    = 8'h2F;
  localparam logic [7:0] TCC_ADDR_PORT_DATA = 8'h30;
  localparam logic [7:0] TCC_ADDR_FLAGS     = 8'h31;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int         TCC_CTC_BIT        = 3;
  localparam int         TCC_PORT_BIT_FIVE  = 5;
  localparam int         TCC_PORT_BIT_FOUR  = 4;
  localparam logic [7:0] TCC_CTRL_B_MASK    = 8'hCF;
  localparam logic [7:0] TCC_CTRL_A_MASK    = 8'hF3;
  localparam logic [7:0] TCC_BYTE_RESET     = 8'h00;
  localparam logic [15:0] TCC_WORD_RESET    = 16'h0000;
  localparam int         TCC_PRESC_W        = 10;

  // ----------------------------------------------------------------
  // pwm top values
  // ----------------------------------------------------------------
  localparam logic [15:0] TCC_TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TCC_TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TCC_TOP_10BIT     = 16'h03FF;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TCC_CS_STOP = 3'h0, TCC_CS_SYS = 3'h1, TCC_CS_DIV8 = 3'h2, TCC_CS_DIV64 = 3'h3,
    TCC_CS_DIV256 = 3'h4, TCC_CS_DIV1024 = 3'h5, TCC_CS_EXT_FALL = 3'h6,
    TCC_CS_EXT_RISE = 3'h7
  } tcc_clk_sel_t;

  typedef enum logic [1:0] {
    TCC_COM_OFF = 2'h0, TCC_COM_TOGGLE = 2'h1, TCC_COM_CLEAR = 2'h2, TCC_COM_SET = 2'h3
  } tcc_com_t;

  typedef enum logic [1:0] {
    TCC_DIR_UP   = 2'b01,
    TCC_DIR_DOWN = 2'b10
  } tcc_dir_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcc_bus_req_t;

  typedef struct packed {
    logic [1:0] value;
    logic [1:0] connected;
  } tcc_pin_out_t;

endpackage : tcc_pkg

/* verilog/tcc_timer16.sv */
`timescale 1ns/1ps

// Overview of operation
// R1: control b bits 5 and 4 always read as zero.
// R2: with clear-on-match set, counter goes to zero one cycle after compare a match.
// R3: with clear-on-match off, compare matches never disturb the counter.
// R4: match seen one clock late; divide-by-8 shows c+1 once, then zero.
// R5: clear-on-match is ignored while pwm mode is active.
// R6: clock select: stop, clk, /8, /64, /256, /1024, pin fall, pin rise.
// R7: software makes the external count pin an input before pin modes.
// R8: 16-bit counter, byte-wise read/write, resets to zero.
// R9: one 8-bit staging latch shared by counter, compares and capture.
// R10: software masks interrupts around shared-latch accesses in main code.
// R11: counter high write goes to latch; low write loads all 16 bits.
// R12: counter low read returns low, latches high; high read returns latch.
// R13: software writes high first, reads low first.
// R14: counts up normally, up then down in pwm mode.
// R15: after a preset, counting resumes from written value next timer tick.
// R16: two 16-bit compare registers continuously compared with the counter.
// R17: only counting into the compare value matches, never a software write.
// R18: compare flag sets in the clock after the compare event.
// R19: port data bits five and four write the two compare output values.
// R20: compare high write goes to latch; low write moves latch in together.
// R21: outside pwm, mode 00 off, 01 toggle, 10 clear, 11 set on match.
// R22: counter steps once per enabled tick or edge, never when stopped.
module tcc_timer16 (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register port
  input  wire tcc_pkg::tcc_bus_req_t bus_req,
  output      logic [7:0]          rd_data,
  // pins and capture value
  input  wire logic                external_count_pin,
  input  wire logic [15:0]         capture_value,
  output      tcc_pkg::tcc_pin_out_t pin_out,
  // compare flags
  output      logic [1:0]          compare_flags
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]            cnt_reg;
  logic [15:0]            cmp_reg [0:1];
  logic [15:0]            cmp_buf_reg [0:1];
  logic [7:0]             temp_reg;
  logic [7:0]             ctrl_a_reg;
  logic [7:0]             ctrl_b_reg;
  logic [TCC_PRESC_W-1:0] presc_reg;
  logic                   ext_sync1_reg;
  logic                   ext_sync2_reg;
  logic                   ext_prev_reg;
  logic                   arrived_reg;
  logic [1:0]             match_pend_reg;
  logic [1:0]             flag_reg;
  logic [1:0]             oc_reg;
  tcc_dir_t               dir_reg;
  logic [7:0]             rd_data_reg;

  logic                   tick;
  logic                   pwm_on;
  logic [15:0]            top;
  logic                   step_up;
  logic [15:0]            cnt_step;
  logic                   clear_now;
  logic                   at_top;
  logic [1:0]             match_now;
  logic                   wr_cnt_low;
  logic                   wr_any_cmp_low;
  tcc_clk_sel_t           clk_sel;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign clk_sel        = tcc_clk_sel_t'(ctrl_b_reg[2:0]);
  assign pwm_on         = (ctrl_a_reg[1:0] != 2'h0);
  assign wr_cnt_low     = bus_req.wr && (bus_req.addr == TCC_ADDR_CNT_LOW);
  assign wr_any_cmp_low = bus_req.wr && ((bus_req.addr == TCC_ADDR_CMPA_LOW) ||
                                         (bus_req.addr == TCC_ADDR_CMPB_LOW));

  always_comb begin
    case (ctrl_a_reg[1:0])
      2'h1:    top = TCC_TOP_8BIT;
      2'h2:    top = TCC_TOP_9BIT;
      default: top = TCC_TOP_10BIT;
    endcase
  end

  // ----------------------------------------------------------------
  // prescaler and external pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg  <= 1'b0;
    end else begin
      ext_sync1_reg <= external_count_pin;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg  <= ext_sync2_reg;
    end
  end

  always_comb begin
    case (clk_sel)
      TCC_CS_STOP:     tick = 1'b0;                          // [R6] [R22]
      TCC_CS_SYS:      tick = 1'b1;                          // [R6]
      TCC_CS_DIV8:     tick = &presc_reg[2:0];               // [R6]
      TCC_CS_DIV64:    tick = &presc_reg[5:0];               // [R6]
      TCC_CS_DIV256:   tick = &presc_reg[7:0];               // [R6]
      TCC_CS_DIV1024:  tick = &presc_reg[9:0];               // [R6]
      TCC_CS_EXT_FALL: tick = ext_prev_reg && !ext_sync2_reg; // [R6] [R7]
      TCC_CS_EXT_RISE: tick = !ext_prev_reg && ext_sync2_reg; // [R6] [R7]
      default:         tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb begin
    if (!pwm_on) begin
      step_up = 1'b1;                                        // [R14]
    end else if (dir_reg == TCC_DIR_UP) begin
      step_up = (cnt_reg < top);                             // [R14]
    end else begin
      step_up = (cnt_reg == TCC_WORD_RESET);                 // [R14]
    end
    cnt_step = step_up ? 16'(cnt_reg + 16'h0001) : 16'(cnt_reg - 16'h0001);
  end

  assign clear_now = match_pend_reg[0] && ctrl_b_reg[TCC_CTC_BIT] && !pwm_on; // [R2] [R3] [R5]
  assign at_top    = pwm_on && tick && (cnt_reg == top);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= TCC_WORD_RESET;                             // [R8]
    end else if (wr_cnt_low) begin
      cnt_reg <= {temp_reg, bus_req.wdata};                  // [R11] [R15]
    end else if (clear_now) begin
      cnt_reg <= TCC_WORD_RESET;                             // [R2] [R4]
    end else if (tick) begin
      cnt_reg <= cnt_step;                                   // [R22]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_reg <= TCC_DIR_UP;
    end else if (!pwm_on) begin
      dir_reg <= TCC_DIR_UP;
    end else if (tick) begin
      case (dir_reg)
        TCC_DIR_UP:   dir_reg <= step_up ? TCC_DIR_UP : TCC_DIR_DOWN; // [R14]
        TCC_DIR_DOWN: dir_reg <= step_up ? TCC_DIR_UP : TCC_DIR_DOWN; // [R14]
        default:      dir_reg <= TCC_DIR_UP;
      endcase
    end
  end

  // counter value reached by counting, not by a write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arrived_reg <= 1'b0;
    end else if (wr_cnt_low || wr_any_cmp_low) begin
      arrived_reg <= 1'b0;                                   // [R17]
    end else if (tick || clear_now) begin
      arrived_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // staging latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_reg <= TCC_BYTE_RESET;
    end else if (bus_req.wr && ((bus_req.addr == TCC_ADDR_CNT_HIGH) ||
                                (bus_req.addr == TCC_ADDR_CMPA_HIGH) ||
                                (bus_req.addr == TCC_ADDR_CMPB_HIGH))) begin
      temp_reg <= bus_req.wdata;                             // [R9] [R11] [R20]
    end else if (bus_req.rd && (bus_req.addr == TCC_ADDR_CNT_LOW)) begin
      temp_reg <= cnt_reg[15:8];                             // [R9] [R12]
    end else if (bus_req.rd && (bus_req.addr == TCC_ADDR_CAPT_LOW)) begin
      temp_reg <= capture_value[15:8];                       // [R9]
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_b_reg <= TCC_BYTE_RESET;
    end else if (bus_req.wr && (bus_req.addr == TCC_ADDR_CTRL_B)) begin
      ctrl_b_reg <= bus_req.wdata & TCC_CTRL_B_MASK;         // [R1]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_reg <= TCC_BYTE_RESET;
    end else if (bus_req.wr && (bus_req.addr == TCC_ADDR_CTRL_A)) begin
      ctrl_a_reg <= bus_req.wdata & TCC_CTRL_A_MASK;
    end
  end

  // ----------------------------------------------------------------
  // compare channels, index 0 is a, index 1 is b
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_cmp
      logic [7:0] low_addr;
      logic [1:0] com;
      logic       port_bit;
      logic       wr_low;

      assign low_addr = (i == 0) ? TCC_ADDR_CMPA_LOW : TCC_ADDR_CMPB_LOW;
      assign com      = (i == 0) ? ctrl_a_reg[7:6] : ctrl_a_reg[5:4];
      assign port_bit = (i == 0) ? bus_req.wdata[TCC_PORT_BIT_FIVE]
                                 : bus_req.wdata[TCC_PORT_BIT_FOUR];
      assign wr_low   = bus_req.wr && (bus_req.addr == low_addr);

      // written value; in pwm it waits here until top
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cmp_buf_reg[i] <= TCC_WORD_RESET;
        end else if (wr_low) begin
          cmp_buf_reg[i] <= {temp_reg, bus_req.wdata};       // [R20]
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cmp_reg[i] <= TCC_WORD_RESET;
        end else if (wr_low && !pwm_on) begin
          cmp_reg[i] <= {temp_reg, bus_req.wdata};           // [R16] [R20]
        end else if (at_top) begin
          cmp_reg[i] <= cmp_buf_reg[i];
        end
      end

      assign match_now[i] = tick && arrived_reg && (cnt_reg == cmp_reg[i]); // [R16] [R17]

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          match_pend_reg[i] <= 1'b0;
        end else begin
          match_pend_reg[i] <= match_now[i];                 // [R4]
        end
      end

      // set wins over a same-cycle clear
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flag_reg[i] <= 1'b0;
        end else if (match_pend_reg[i]) begin
          flag_reg[i] <= 1'b1;                               // [R18]
        end else if (bus_req.wr && (bus_req.addr == TCC_ADDR_FLAGS) &&
                     bus_req.wdata[i]) begin
          flag_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          oc_reg[i] <= 1'b0;
        end else if (match_pend_reg[i] && !pwm_on) begin
          case (tcc_com_t'(com))
            TCC_COM_OFF:    oc_reg[i] <= oc_reg[i];          // [R21]
            TCC_COM_TOGGLE: oc_reg[i] <= !oc_reg[i];         // [R21]
            TCC_COM_CLEAR:  oc_reg[i] <= 1'b0;               // [R21]
            TCC_COM_SET:    oc_reg[i] <= 1'b1;               // [R21]
            default:        oc_reg[i] <= oc_reg[i];
          endcase
        end else if (match_pend_reg[i] && com[1]) begin
          oc_reg[i] <= com[0] ^ (dir_reg == TCC_DIR_DOWN);
        end else if (bus_req.wr && (bus_req.addr == TCC_ADDR_PORT_DATA)) begin
          oc_reg[i] <= port_bit;                             // [R19]
        end
      end

      assign pin_out.connected[i] = pwm_on ? com[1] : (com != 2'h0);
    end
  endgenerate

  assign pin_out.value = oc_reg;
  assign compare_flags = flag_reg;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= TCC_BYTE_RESET;
    end else if (!bus_req.rd) begin
      rd_data_reg <= TCC_BYTE_RESET;
    end else begin
      case (bus_req.addr)
        TCC_ADDR_CAPT_LOW:  rd_data_reg <= capture_value[7:0];
        TCC_ADDR_CAPT_HIGH: rd_data_reg <= temp_reg;                   // [R9]
        TCC_ADDR_CMPB_LOW:  rd_data_reg <= cmp_buf_reg[1][7:0];
        TCC_ADDR_CMPB_HIGH: rd_data_reg <= cmp_buf_reg[1][15:8];
        TCC_ADDR_CMPA_LOW:  rd_data_reg <= cmp_buf_reg[0][7:0];
        TCC_ADDR_CMPA_HIGH: rd_data_reg <= cmp_buf_reg[0][15:8];
        TCC_ADDR_CNT_LOW:   rd_data_reg <= cnt_reg[7:0];               // [R12]
        TCC_ADDR_CNT_HIGH:  rd_data_reg <= temp_reg;                   // [R12]
        TCC_ADDR_CTRL_B:    rd_data_reg <= ctrl_b_reg & TCC_CTRL_B_MASK; // [R1]
        TCC_ADDR_CTRL_A:    rd_data_reg <= ctrl_a_reg;
        TCC_ADDR_PORT_DATA: rd_data_reg <= {2'h0, oc_reg[0], oc_reg[1], 4'h0};
        TCC_ADDR_FLAGS:     rd_data_reg <= {6'h00, flag_reg};
        default:            rd_data_reg <= TCC_BYTE_RESET;
      endcase
    end
  end

  assign rd_data = rd_data_reg;

endmodule : tcc_timer16

/* verification/tcc_timer16_monitor.sv */
`timescale 1ns/1ps
module tcc_timer16_monitor (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // register port
  input wire tcc_pkg::tcc_bus_req_t bus_req,
  input wire logic [7:0]            rd_data,
  // pins and flags
  input wire logic                  external_count_pin,
  input wire logic [15:0]           capture_value,
  input wire tcc_pkg::tcc_pin_out_t pin_out,
  input wire logic [1:0]            compare_flags
);
  import tcc_pkg::*;
  // ----------------------------------------------------------------
  // register port relations
  // ----------------------------------------------------------------
  wire       w = bus_req.wr;
  wire       r = bus_req.rd;
  wire [7:0] a = bus_req.addr;
  wire [7:0] d = bus_req.wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ctrl_b_rsvd_a: assert property (r && a == TCC_ADDR_CTRL_B |=> rd_data[5:4] == 2'b00)
    else $error("reserved control bits read nonzero");
  unmapped_rd_a: assert property (r && (a < TCC_ADDR_CAPT_LOW || a > TCC_ADDR_FLAGS)
    |=> rd_data == 8'h00) else $error("unmapped read nonzero");
  rd_idle_a: assert property (!r |=> rd_data == 8'h00)
    else $error("read data outside read cycle");
  capt_low_a: assert property (r && a == TCC_ADDR_CAPT_LOW
    |=> rd_data == $past(capture_value[7:0])) else $error("capture low byte wrong");
  capt_pair_a: assert property (r && a == TCC_ADDR_CAPT_LOW ##1 r && a == TCC_ADDR_CAPT_HIGH
    |=> rd_data == $past(capture_value[15:8], 2)) else $error("capture high byte wrong");
  cmpa_pair_a: assert property (w && a == TCC_ADDR_CMPA_HIGH ##1 w && a == TCC_ADDR_CMPA_LOW
    ##1 r && a == TCC_ADDR_CMPA_HIGH |=> rd_data == $past(d, 3)) else $error("compare high wrong");
  cmpb_low_a: assert property (w && a == TCC_ADDR_CMPB_HIGH ##1 w && a == TCC_ADDR_CMPB_LOW
    ##1 r && a == TCC_ADDR_CMPB_LOW |=> rd_data == $past(d, 2)) else $error("compare low wrong");
  cnt_preset_a: assert property (w && a == TCC_ADDR_CNT_HIGH ##1 w && a == TCC_ADDR_CNT_LOW
    ##1 r && a == TCC_ADDR_CNT_LOW |=> rd_data == $past(d, 2)) else $error("preset not loaded");
  cnt_latch_a: assert property (r && a == TCC_ADDR_CNT_LOW ##1 w && a == TCC_ADDR_CNT_HIGH
    ##1 r && a == TCC_ADDR_CNT_HIGH |=> rd_data == $past(d, 2)) else $error("shared latch wrong");
  pin_connect_a: assert property (w && a == TCC_ADDR_CTRL_A && d[1:0] == 2'b00
    |=> pin_out.connected == {|$past(d[5:4]), |$past(d[7:6])}) else $error("pin drive wrong");
  cover property ($rose(compare_flags[0]));
  cover property ($changed(pin_out.value));
  cover property (r ##1 r);
endmodule : tcc_timer16_monitor

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import tcc_pkg::*;
  logic               clk;
  logic               rst;
  tcc_bus_req_t       bus_req;
  logic [7:0]         rd_data;
  logic               ext_pin;
  logic [15:0]        capture_value;
  tcc_pin_out_t       pin_out;
  logic [1:0]         compare_flags;
  int                 miscompares;
  int                 num_checks;
  logic [7:0]         exp_q[$];
  logic               rd_pend;
  logic [7:0]         rd_adr;
  int                 div_tab[5] = '{1, 8, 64, 256, 1024};

  tcc_timer16 u_dut (
    .clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .external_count_pin(ext_pin), .capture_value(capture_value),
    .pin_out(pin_out), .compare_flags(compare_flags));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    num_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, d, w, r};
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic gap(input int n);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (n - 1) @(posedge clk);
  endtask : gap

  // one master only, accesses never interleaved
  task automatic cset(input logic [15:0] v);
    wr(TCC_ADDR_CNT_HIGH, v[15:8]);
    wr(TCC_ADDR_CNT_LOW, v[7:0]);
    rd(TCC_ADDR_CNT_LOW, v[7:0]);
  endtask : cset

  task automatic summarize;
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    if (rd_pend) chk($sformatf("read %h", rd_adr), exp_q.pop_front(), rd_data);
    rd_pend = bus_req.rd;
    rd_adr = bus_req.addr;
  end

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    summarize();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bus_req = '0;
    ext_pin = 1'b0;
    capture_value = 16'hbeef;
    miscompares = 0;
    num_checks = 0;
    rd_pend = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'h28; a <= 8'h2e; a++) rd(8'(a), 8'h00);
    wr(TCC_ADDR_CTRL_B, 8'hf0);
    rd(TCC_ADDR_CTRL_B, 8'hc0);
    wr(TCC_ADDR_CTRL_A, 8'hff);
    rd(TCC_ADDR_CTRL_A, 8'hf3);
    wr(TCC_ADDR_CTRL_A, 8'h00);
    wr(TCC_ADDR_CTRL_B, 8'h00);
    wr(8'h40, 8'h5a);
    rd(8'h40, 8'h00);
    wr(TCC_ADDR_CMPA_HIGH, 8'h12);
    wr(TCC_ADDR_CMPA_LOW, 8'h34);
    rd(TCC_ADDR_CMPA_HIGH, 8'h12);
    rd(TCC_ADDR_CMPA_LOW, 8'h34);
    wr(TCC_ADDR_CMPB_HIGH, 8'hab);
    wr(TCC_ADDR_CMPB_LOW, 8'hcd);
    rd(TCC_ADDR_CMPB_LOW, 8'hcd);
    wr(TCC_ADDR_CMPA_HIGH, 8'h77);
    rd(TCC_ADDR_CMPA_HIGH, 8'h12);
    rd(TCC_ADDR_CMPB_HIGH, 8'hab);
    rd(TCC_ADDR_CAPT_LOW, 8'hef);
    rd(TCC_ADDR_CAPT_HIGH, 8'hbe);
    cset(16'h1234);
    wr(TCC_ADDR_CNT_HIGH, 8'h99);
    rd(TCC_ADDR_CNT_HIGH, 8'h99);
    gap(20);
    rd(TCC_ADDR_CNT_LOW, 8'h34);
    rd(TCC_ADDR_CNT_HIGH, 8'h12);
    for (int i = 0; i < 5; i++) begin
      wr(TCC_ADDR_CTRL_B, 8'(i + 1));
      cset(16'h00fe);
      gap(4 * div_tab[i] - 1);
      rd(TCC_ADDR_CNT_LOW, 8'h02);
      rd(TCC_ADDR_CNT_HIGH, 8'h01);
    end
    for (int s = 7; s >= 6; s--) begin
      wr(TCC_ADDR_CTRL_B, 8'(s));
      cset(16'h0010);
      gap(1);
      repeat (6) begin
        repeat (4) @(posedge clk);
        ext_pin <= ~ext_pin; // pin kept an input
      end
      gap(6);
      rd(TCC_ADDR_CNT_LOW, 8'h13);
    end
    wr(TCC_ADDR_CTRL_B, 8'h00);
    wr(TCC_ADDR_CMPA_HIGH, 8'h00);
    wr(TCC_ADDR_CMPA_LOW, 8'h10);
    wr(TCC_ADDR_CMPB_HIGH, 8'h00);
    wr(TCC_ADDR_CMPB_LOW, 8'h10);
    for (int m = 0; m < 4; m++) begin
      wr(TCC_ADDR_CTRL_A, 8'(m * 8'h50));
      wr(TCC_ADDR_PORT_DATA, (m == 2) ? 8'h30 : 8'h00);
      wr(TCC_ADDR_FLAGS, 8'h03);
      gap(1);
      @(negedge clk);
      chk("pin values", 8'({2{m == 2}}), 8'(pin_out.value));
      chk("match flags", 8'h00, 8'(compare_flags));
      wr(TCC_ADDR_CTRL_B, 8'h09);
      cset(16'h000e);
      gap(3);
      rd(TCC_ADDR_CNT_LOW, 8'h00);
      rd(TCC_ADDR_CNT_HIGH, 8'h00);
      wr(TCC_ADDR_CTRL_B, 8'h00);
      gap(1);
      @(negedge clk);
      chk("match flags", 8'h03, 8'(compare_flags));
      chk("pin drive", 8'({2{m != 0}}), 8'(pin_out.connected));
      if (m > 0) chk("pin values", 8'({2{m != 2}}), 8'(pin_out.value));
    end
    for (int k = 0; k < 2; k++) begin
      wr(TCC_ADDR_CTRL_A, 8'(k));
      wr(TCC_ADDR_CTRL_B, 8'(1 + 8 * k));
      cset(16'h000e);
      gap(3);
      rd(TCC_ADDR_CNT_LOW, 8'h12);
      wr(TCC_ADDR_CTRL_B, 8'h00);
    end
    // pwm turn at top: up to top, then down, for each width
    for (int p = 1; p < 4; p++) begin
      logic [15:0] tv;
      tv = (p == 1) ? TCC_TOP_8BIT : (p == 2) ? TCC_TOP_9BIT : TCC_TOP_10BIT;
      wr(TCC_ADDR_CTRL_A, 8'(p));
      wr(TCC_ADDR_CTRL_B, 8'h01);
      cset(tv - 16'h0001);
      gap(3);
      rd(TCC_ADDR_CNT_LOW, 8'(tv - 16'h0003));
      rd(TCC_ADDR_CNT_HIGH, tv[15:8]);
      wr(TCC_ADDR_CTRL_A, 8'h00);
      wr(TCC_ADDR_CTRL_B, 8'h00);
    end
    wr(TCC_ADDR_CTRL_A, 8'h00);
    wr(TCC_ADDR_FLAGS, 8'h03);
    wr(TCC_ADDR_CTRL_B, 8'h01);
    wr(TCC_ADDR_CNT_HIGH, 8'h00);
    wr(TCC_ADDR_CNT_LOW, 8'h10);
    wr(TCC_ADDR_CTRL_B, 8'h00);
    gap(4);
    @(negedge clk);
    chk("match flags", 8'h00, 8'(compare_flags));
    gap(3);
    summarize();
  end
endmodule : tb_top

bind tcc_timer16 tcc_timer16_monitor u_mon (
  .clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
  .external_count_pin(external_count_pin), .capture_value(capture_value),
  .pin_out(pin_out), .compare_flags(compare_flags));
